// File: design/radio_synth_cal_test_status_regs.sv
// synthesizer calibration, sleep-volatile test and read-only status registers
// Overview of operation
// [RULE1] A zero pump current calibration enable field skips the charge pump calibration stage.
// [RULE2] Bits 3:0 of the pump register hold the pump current result, read/write, reset nine.
// [RULE3] Bit 5 of the oscillator current register picks the high core when set, reset zero.
// [RULE4] The five-bit oscillator current field stores the result and overrides it when written.
// [RULE5] The six-bit coarse tune field holds the capacitor array setting, reset thirty-two.
// [RULE6] Oscillator selection calibration runs only while test zero bit 1 is set, reset one.
// [RULE7] Registers 0x29 to 0x2e lose their contents in sleep and return to reset values.
// [RULE8] On wake-up test two takes 0x88 or 0x81 internally, by converter retention.
// [RULE9] After wake-up test two reads its reset value whatever the retention setting.
// [RULE10] On wake-up test one takes 0x31 or 0x35 internally, by converter retention.
// [RULE11] After wake-up test one reads its reset value whatever the retention setting.
// [RULE12] The carrier offset estimate reads as a read-only signed eight-bit value.
// [RULE13] Offset compensation is enabled only for two-level, four-level and Gaussian keying.
// [RULE14] Under on-off keying the carrier offset estimate always reads zero.
// [RULE15] CRC status bit 7 sets on a matching CRC and clears on entering or restarting receive.
// [RULE16] Signal strength reads as a read-only eight-bit register.
// [RULE17] Identity and status registers ignore writes.
`timescale 1ns/1ns
`default_nettype none

module radio_synth_cal_test_status_regs
    import synth_regs_pkg::*;
#(
    parameter logic [7:0] PART_ID     = 8'h5a, // arbitrary identity value
    parameter logic [7:0] REVISION_ID = 8'h17  // arbitrary identity value
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,

    // register access from the serial interface engine
    input  wire logic        i_reg_write,
    input  wire logic [5:0]  i_reg_addr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,

    // radio core status
    input  wire logic        i_sleep,
    input  wire logic        i_converter_retention_setting,
    input  wire logic [1:0]  i_modulation,
    input  wire logic        i_offset_valid,
    input  wire logic [7:0]  i_carrier_offset_value,
    input  wire logic        i_crc_done,
    input  wire logic        i_crc_match,
    input  wire logic        i_rx_start,
    input  wire logic        i_signal_strength_valid,
    input  wire logic [7:0]  i_signal_strength,
    input  wire logic        i_cal_write,
    input  wire logic [3:0]  i_pump_cal_result,
    input  wire logic [4:0]  i_vco_cal_result,
    input  wire logic [5:0]  i_coarse_cal_result,

    // controls to the synthesizer and analog part
    output logic             o_pump_cal_stage_enable,
    output logic             o_oscillator_core_select,
    output logic             o_oscillator_select_cal_enable,
    output logic             o_offset_comp_enable,
    output logic [3:0]       o_pump_current,
    output logic [4:0]       o_vco_current,
    output logic [5:0]       o_coarse_tune,
    output logic [7:0]       o_test_setting_two_eff,
    output logic [7:0]       o_test_setting_one_eff,
    output logic [7:0]       o_test_setting_zero_eff
);

    logic [7:0] synth_cal_pump;
    logic [7:0] synth_cal_vco_current;
    logic [7:0] synth_cal_coarse_tune;
    logic [7:0] synth_cal_control;
    logic [7:0] reserved_setting_a;
    logic [7:0] reserved_setting_b;
    logic [7:0] reserved_setting_c;
    logic [7:0] test_setting_two;
    logic [7:0] test_setting_one;
    logic [7:0] test_setting_zero;

    // effective copies seen by the analog part, never by the host
    logic [7:0] test_two_internal;
    logic [7:0] test_one_internal;

    // captured status
    logic [7:0] carrier_offset_estimate;
    logic       crc_match_flag;
    logic [7:0] signal_strength;

    // synchroniser stages
    logic       sleep_meta;
    logic       sleep_sync;
    logic       sleep_prev;
    logic       retain_meta;
    logic       retain_sync;

    wire logic  wake_up = sleep_prev && !sleep_sync;
    wire logic  asleep  = sleep_sync;

    function automatic logic wr_hit(input logic [5:0] addr);
        wr_hit = i_reg_write && (i_reg_addr == addr);
    endfunction

    wire logic wr_pump     = wr_hit(ADDR_SYNTH_CAL_PUMP);
    wire logic wr_vco      = wr_hit(ADDR_SYNTH_CAL_VCO_CURRENT);
    wire logic wr_coarse   = wr_hit(ADDR_SYNTH_CAL_COARSE_TUNE);
    wire logic wr_control  = wr_hit(ADDR_SYNTH_CAL_CONTROL);
    wire logic wr_res_a    = wr_hit(ADDR_RESERVED_SETTING_A);
    wire logic wr_res_b    = wr_hit(ADDR_RESERVED_SETTING_B);
    wire logic wr_res_c    = wr_hit(ADDR_RESERVED_SETTING_C);
    wire logic wr_test_two = wr_hit(ADDR_TEST_SETTING_TWO);
    wire logic wr_test_one = wr_hit(ADDR_TEST_SETTING_ONE);
    wire logic wr_test_zero = wr_hit(ADDR_TEST_SETTING_ZERO);

    wire logic is_ook = (modulation_t'(i_modulation) == MOD_OOK);

    // sleep and retention come from the always-on domain; synchronise them
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            sleep_meta  <= 1'b0;
            sleep_sync  <= 1'b0;
            sleep_prev  <= 1'b0;
            retain_meta <= 1'b0;
            retain_sync <= 1'b0;
        end else begin
            sleep_meta  <= i_sleep;
            sleep_sync  <= sleep_meta;
            sleep_prev  <= sleep_sync;
            retain_meta <= i_converter_retention_setting;
            retain_sync <= retain_meta;
        end
    end

    // calibration registers: host write wins over a calibration result,
    // so a manual override is never lost to a finishing calibration
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            synth_cal_pump <= RST_SYNTH_CAL_PUMP;
        end else if (wr_pump) begin
            synth_cal_pump <= i_reg_wdata; // RULE2
        end else if (i_cal_write) begin
            synth_cal_pump[3:0] <= i_pump_cal_result; // RULE2
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            synth_cal_vco_current <= RST_SYNTH_CAL_VCO_CURRENT;
        end else if (wr_vco) begin
            synth_cal_vco_current <= i_reg_wdata & MASK_VCO_CURRENT; // RULE4
        end else if (i_cal_write) begin
            synth_cal_vco_current[4:0] <= i_vco_cal_result; // RULE4
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            synth_cal_coarse_tune <= RST_SYNTH_CAL_COARSE_TUNE;
        end else if (wr_coarse) begin
            synth_cal_coarse_tune <= i_reg_wdata & MASK_COARSE_TUNE; // RULE5
        end else if (i_cal_write) begin
            synth_cal_coarse_tune[5:0] <= i_coarse_cal_result; // RULE5
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            synth_cal_control <= RST_SYNTH_CAL_CONTROL;
        end else if (wr_control) begin
            synth_cal_control <= i_reg_wdata & MASK_CONTROL;
        end
    end

    // sleep-volatile group: held at reset values while asleep;
    // host writes during sleep are dropped, not queued
    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            reserved_setting_a <= RST_RESERVED_SETTING_A; // RULE7
        end else if (wr_res_a) begin
            reserved_setting_a <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            reserved_setting_b <= RST_RESERVED_SETTING_B; // RULE7
        end else if (wr_res_b) begin
            reserved_setting_b <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            reserved_setting_c <= RST_RESERVED_SETTING_C; // RULE7
        end else if (wr_res_c) begin
            reserved_setting_c <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            test_setting_two <= RST_TEST_SETTING_TWO; // RULE7
        end else if (wr_test_two) begin
            test_setting_two <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            test_setting_one <= RST_TEST_SETTING_ONE; // RULE7
        end else if (wr_test_one) begin
            test_setting_one <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst || asleep) begin
            test_setting_zero <= RST_TEST_SETTING_ZERO; // RULE7
        end else if (wr_test_zero) begin
            test_setting_zero <= i_reg_wdata;
        end
    end

    // internal copies: forced on wake-up, follow host writes afterwards;
    // the readable copies stay at reset values, only these differ
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            test_two_internal <= RST_TEST_SETTING_TWO;
        end else if (wake_up) begin
            test_two_internal <= retain_sync ? WAKE_TEST_TWO_RETAIN
                                             : RST_TEST_SETTING_TWO; // RULE8
        end else if (wr_test_two) begin
            test_two_internal <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            test_one_internal <= RST_TEST_SETTING_ONE;
        end else if (wake_up) begin
            test_one_internal <= retain_sync ? WAKE_TEST_ONE_RETAIN
                                             : RST_TEST_SETTING_ONE; // RULE10
        end else if (wr_test_one) begin
            test_one_internal <= i_reg_wdata;
        end
    end

    // status captures hold until the next capture pulse
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            carrier_offset_estimate <= 8'h00;
        end else if (i_offset_valid) begin
            carrier_offset_estimate <= i_carrier_offset_value; // RULE12
        end
    end

    // crc set wins over the receive-start clear: a result in the same
    // cycle as a restart belongs to the packet just finished
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            crc_match_flag <= 1'b0;
        end else if (i_crc_done) begin
            crc_match_flag <= i_crc_match; // RULE15
        end else if (i_rx_start) begin
            crc_match_flag <= 1'b0; // RULE15
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            signal_strength <= 8'h00;
        end else if (i_signal_strength_valid) begin
            signal_strength <= i_signal_strength; // RULE16
        end
    end

    // read mux; status addresses have no write path
    always_comb begin
        unique case (i_reg_addr)
            ADDR_SYNTH_CAL_PUMP:        o_reg_rdata = synth_cal_pump;
            ADDR_SYNTH_CAL_VCO_CURRENT: o_reg_rdata = synth_cal_vco_current;
            ADDR_SYNTH_CAL_COARSE_TUNE: o_reg_rdata = synth_cal_coarse_tune;
            ADDR_SYNTH_CAL_CONTROL:     o_reg_rdata = synth_cal_control;
            ADDR_RESERVED_SETTING_A:    o_reg_rdata = reserved_setting_a;
            ADDR_RESERVED_SETTING_B:    o_reg_rdata = reserved_setting_b;
            ADDR_RESERVED_SETTING_C:    o_reg_rdata = reserved_setting_c;
            ADDR_TEST_SETTING_TWO:      o_reg_rdata = test_setting_two; // RULE9
            ADDR_TEST_SETTING_ONE:      o_reg_rdata = test_setting_one; // RULE11
            ADDR_TEST_SETTING_ZERO:     o_reg_rdata = test_setting_zero;
            ADDR_CHIP_PART_ID:          o_reg_rdata = PART_ID; // RULE17
            ADDR_CHIP_REVISION_ID:      o_reg_rdata = REVISION_ID; // RULE17
            ADDR_CARRIER_OFFSET_EST:
                o_reg_rdata = is_ook ? 8'h00 : carrier_offset_estimate; // RULE14
            ADDR_CRC_MATCH_STATUS:
                o_reg_rdata = {crc_match_flag, 7'h00};
            ADDR_SIGNAL_STRENGTH:       o_reg_rdata = signal_strength; // RULE16
            default:                    o_reg_rdata = 8'h00;
        endcase
    end

    assign o_pump_cal_stage_enable =
        (synth_cal_pump[PUMP_CAL_EN_LSB+1:PUMP_CAL_EN_LSB] != 2'b00); // RULE1
    assign o_oscillator_core_select       = synth_cal_vco_current[CORE_SELECT_BIT]; // RULE3
    assign o_oscillator_select_cal_enable = test_setting_zero[OSC_SEL_CAL_BIT]; // RULE6
    assign o_offset_comp_enable           = !is_ook; // RULE13
    assign o_pump_current                 = synth_cal_pump[3:0];
    assign o_vco_current                  = synth_cal_vco_current[4:0];
    assign o_coarse_tune                  = synth_cal_coarse_tune[5:0];
    assign o_test_setting_two_eff         = test_two_internal;
    assign o_test_setting_one_eff         = test_one_internal;
    assign o_test_setting_zero_eff        = test_setting_zero;

endmodule

`default_nettype wire

// File: design/synth_regs_pkg.sv
// constants for the synthesizer calibration, test and status register bank
package synth_regs_pkg;
    localparam logic [5:0] ADDR_SYNTH_CAL_PUMP        = 6'h23;
    localparam logic [5:0] ADDR_SYNTH_CAL_VCO_CURRENT = 6'h24;
    localparam logic [5:0] ADDR_SYNTH_CAL_COARSE_TUNE = 6'h25;
    localparam logic [5:0] ADDR_SYNTH_CAL_CONTROL     = 6'h26;
    localparam logic [5:0] ADDR_RESERVED_SETTING_A    = 6'h29;
    localparam logic [5:0] ADDR_RESERVED_SETTING_B    = 6'h2a;
    localparam logic [5:0] ADDR_RESERVED_SETTING_C    = 6'h2b;
    localparam logic [5:0] ADDR_TEST_SETTING_TWO      = 6'h2c;
    localparam logic [5:0] ADDR_TEST_SETTING_ONE      = 6'h2d;
    localparam logic [5:0] ADDR_TEST_SETTING_ZERO     = 6'h2e;
    localparam logic [5:0] ADDR_CHIP_PART_ID          = 6'h30;
    localparam logic [5:0] ADDR_CHIP_REVISION_ID      = 6'h31;
    localparam logic [5:0] ADDR_CARRIER_OFFSET_EST    = 6'h32;
    localparam logic [5:0] ADDR_CRC_MATCH_STATUS      = 6'h33;
    localparam logic [5:0] ADDR_SIGNAL_STRENGTH       = 6'h34;

    // reset values
    localparam logic [7:0] RST_SYNTH_CAL_PUMP        = 8'ha9;
    localparam logic [7:0] RST_SYNTH_CAL_VCO_CURRENT = 8'h0a;
    localparam logic [7:0] RST_SYNTH_CAL_COARSE_TUNE = 8'h20;
    localparam logic [7:0] RST_SYNTH_CAL_CONTROL     = 8'h0d;
    localparam logic [7:0] RST_RESERVED_SETTING_A    = 8'h59;
    localparam logic [7:0] RST_RESERVED_SETTING_B    = 8'h7f;
    localparam logic [7:0] RST_RESERVED_SETTING_C    = 8'h3f;
    localparam logic [7:0] RST_TEST_SETTING_TWO      = 8'h88;
    localparam logic [7:0] RST_TEST_SETTING_ONE      = 8'h31;
    localparam logic [7:0] RST_TEST_SETTING_ZERO     = 8'h0b;

    // values forced on wake-up when converter retention is set
    localparam logic [7:0] WAKE_TEST_TWO_RETAIN = 8'h81;
    localparam logic [7:0] WAKE_TEST_ONE_RETAIN = 8'h35;

    // writable-bit masks
    localparam logic [7:0] MASK_VCO_CURRENT = 8'h3f;
    localparam logic [7:0] MASK_COARSE_TUNE = 8'h3f;
    localparam logic [7:0] MASK_CONTROL     = 8'h7f;

    // field positions
    localparam int PUMP_CAL_EN_LSB  = 4;
    localparam int CORE_SELECT_BIT  = 5;
    localparam int OSC_SEL_CAL_BIT  = 1;
    localparam int CRC_MATCH_BIT    = 7;

    typedef enum logic [1:0] {
        MOD_FSK2,
        MOD_GFSK,
        MOD_OOK,
        MOD_FSK4
    } modulation_t;
endpackage

// File: verif/host_model.sv
// host microcontroller model issuing register writes and reads
`timescale 1ns/1ns
`default_nettype none
module host_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    output var  logic       o_write,
    output var  logic [5:0] o_addr,
    output var  logic [7:0] o_wdata
);
    initial begin
        o_write = 1'b0;
        o_addr  = 6'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_write = 1'b1;
        o_addr  = a;
        o_wdata = d;
        @(posedge i_clock);
        #1;
        o_write = 1'b0;
        // data is not held after the strobe, so a stale copy must not be relied on
        o_wdata = ~d;
    endtask
    // address stays put after a read, so status pulses can be watched in place
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_addr = a;
        #5;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// File: verif/radio_synth_cal_test_status_regs_tb_top.sv
// testbench for the synthesizer calibration, test and status registers
`timescale 1ns/1ns
`default_nettype none
module radio_synth_cal_test_status_regs_tb_top;
    import synth_regs_pkg::*;
    logic       i_clock = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_reg_write;
    logic [5:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata, i_carrier_offset_value = 8'h00, i_signal_strength = 8'h00;
    logic       i_sleep = 1'b0, i_converter_retention_setting = 1'b0, i_offset_valid = 1'b0;
    logic       i_crc_done = 1'b0, i_crc_match = 1'b0, i_rx_start = 1'b0, i_signal_strength_valid = 1'b0;
    logic [1:0] i_modulation = MOD_FSK2;
    logic       o_pump_cal_stage_enable, o_oscillator_core_select;
    logic       o_oscillator_select_cal_enable, o_offset_comp_enable;
    logic [3:0] o_pump_current;
    logic [4:0] o_vco_current;
    logic [5:0] o_coarse_tune;
    logic [7:0] o_test_setting_two_eff, o_test_setting_one_eff, o_test_setting_zero_eff;
    logic       i_cal_write = 1'b0;
    logic [3:0] i_pump_cal_result = 4'h0;
    logic [4:0] i_vco_cal_result = 5'h00;
    logic [5:0] i_coarse_cal_result = 6'h00;
    int         mismatches = 0;
    int         n_checks = 0;
    always #10 i_clock = ~i_clock;
    radio_synth_cal_test_status_regs #(.PART_ID(8'h3c), .REVISION_ID(8'h21)) dut (
        .i_clock, .i_rst, .i_reg_write, .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_sleep,
        .i_converter_retention_setting, .i_modulation, .i_offset_valid, .i_carrier_offset_value,
        .i_crc_done, .i_crc_match, .i_rx_start, .i_signal_strength_valid, .i_signal_strength, .i_cal_write,
        .i_pump_cal_result, .i_vco_cal_result, .i_coarse_cal_result,
        .o_pump_cal_stage_enable, .o_oscillator_core_select, .o_oscillator_select_cal_enable,
        .o_offset_comp_enable, .o_pump_current, .o_vco_current, .o_coarse_tune,
        .o_test_setting_two_eff, .o_test_setting_one_eff, .o_test_setting_zero_eff);
    host_model host (.i_clock, .i_rdata(o_reg_rdata), .o_write(i_reg_write),
        .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk($sformatf("register %h", a), exp, d);
    endtask
    task automatic final_report;
        if (mismatches == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic t_reset_and_config;
        rchk(ADDR_SYNTH_CAL_PUMP, RST_SYNTH_CAL_PUMP);
        rchk(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h0a);
        rchk(ADDR_SYNTH_CAL_COARSE_TUNE, 8'h20);
        rchk(ADDR_TEST_SETTING_ZERO, RST_TEST_SETTING_ZERO);
        rchk(6'h27, 8'h00);
        host.wr(ADDR_SYNTH_CAL_PUMP, 8'hc5);
        host.wr(ADDR_SYNTH_CAL_VCO_CURRENT, 8'hff);
        host.wr(ADDR_SYNTH_CAL_COARSE_TUNE, 8'hff);
        host.wr(ADDR_TEST_SETTING_ZERO, 8'hfd);
        rchk(ADDR_SYNTH_CAL_PUMP, 8'hc5);
        chk("pump stage", 8'h00, {7'h0, o_pump_cal_stage_enable});
        chk("pump current", 8'h05, {4'h0, o_pump_current});
        rchk(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h3f);
        chk("core select", 8'h01, {7'h0, o_oscillator_core_select});
        rchk(ADDR_SYNTH_CAL_COARSE_TUNE, 8'h3f);
        rchk(ADDR_TEST_SETTING_ZERO, 8'hfd);
        chk("osc select cal", 8'h00, {7'h0, o_oscillator_select_cal_enable});
        chk("test zero eff", 8'hfd, o_test_setting_zero_eff);
    endtask
    task automatic t_cal_load;
        @(posedge i_clock);
        #1 i_cal_write = 1'b1;
        i_pump_cal_result = 4'h6;
        i_vco_cal_result = 5'h13;
        i_coarse_cal_result = 6'h2a;
        @(posedge i_clock);
        #1 i_cal_write = 1'b0;
        chk("pump cal", 8'h06, {4'h0, o_pump_current});
        chk("vco cal", 8'h13, {3'h0, o_vco_current});
        chk("coarse cal", 8'h2a, {2'h0, o_coarse_tune});
        rchk(ADDR_SYNTH_CAL_PUMP, 8'hc6);
        rchk(ADDR_SYNTH_CAL_VCO_CURRENT, 8'h33);
        rchk(ADDR_SYNTH_CAL_COARSE_TUNE, 8'h2a);
    endtask
    task automatic t_status;
        rchk(ADDR_CRC_MATCH_STATUS, 8'h00);
        @(posedge i_clock);
        #1 {i_offset_valid, i_crc_done, i_crc_match, i_signal_strength_valid} = 4'hf;
        {i_carrier_offset_value, i_signal_strength} = 16'h9cc5;
        @(posedge i_clock);
        #1 {i_offset_valid, i_crc_done, i_crc_match, i_signal_strength_valid} = 4'h0;
        {i_carrier_offset_value, i_signal_strength} = 16'h6335;
        rchk(ADDR_CRC_MATCH_STATUS, 8'h80);
        @(posedge i_clock);
        #1 i_rx_start = 1'b1;
        @(posedge i_clock);
        #1 i_rx_start = 1'b0;
        rchk(ADDR_CRC_MATCH_STATUS, 8'h00);
        rchk(ADDR_SIGNAL_STRENGTH, 8'hc5);
        rchk(ADDR_CARRIER_OFFSET_EST, 8'h9c);
        for (int a = 'h30; a <= 'h34; a++) host.wr(a[5:0], 8'hff);
        rchk(ADDR_CHIP_PART_ID, 8'h3c);
        rchk(ADDR_CHIP_REVISION_ID, 8'h21);
        rchk(ADDR_CARRIER_OFFSET_EST, 8'h9c);
        @(posedge i_clock);
        #1 i_modulation = MOD_OOK;
        rchk(ADDR_CARRIER_OFFSET_EST, 8'h00);
        chk("comp enable", 8'h00, {7'h0, o_offset_comp_enable});
        @(posedge i_clock);
        #1 i_modulation = MOD_FSK4;
        rchk(ADDR_CARRIER_OFFSET_EST, 8'h9c);
        chk("comp enable", 8'h01, {7'h0, o_offset_comp_enable});
    endtask
    task automatic t_sleep_wake;
        for (int r = 0; r < 2; r++) begin
            host.wr(ADDR_TEST_SETTING_TWO, 8'h12);
            host.wr(ADDR_RESERVED_SETTING_A, 8'h00);
            @(posedge i_clock);
            #1 {i_sleep, i_converter_retention_setting} = {1'b1, r[0]};
            repeat (4) @(posedge i_clock);
            host.wr(ADDR_TEST_SETTING_ONE, 8'h00);
            rchk(ADDR_RESERVED_SETTING_A, RST_RESERVED_SETTING_A);
            rchk(ADDR_TEST_SETTING_ONE, RST_TEST_SETTING_ONE);
            @(posedge i_clock);
            #1 i_sleep = 1'b0;
            repeat (6) @(posedge i_clock);
            rchk(ADDR_TEST_SETTING_TWO, 8'h88);
            rchk(ADDR_TEST_SETTING_ONE, 8'h31);
            chk("two eff", r ? WAKE_TEST_TWO_RETAIN : 8'h88, o_test_setting_two_eff);
            chk("one eff", r ? WAKE_TEST_ONE_RETAIN : 8'h31, o_test_setting_one_eff);
        end
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        #1 i_rst = 1'b0;
        t_reset_and_config();
        t_cal_load();
        t_status();
        t_sleep_wake();
        final_report();
    end
    // the whole run takes about a hundred cycles
    initial begin
        #(3000 * 20);
        mismatches++;
        final_report();
    end
endmodule
bind radio_synth_cal_test_status_regs synth_regs_monitor mon (.i_clock, .i_rst, .i_reg_write,
    .i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_modulation, .i_crc_done, .i_crc_match,
    .i_rx_start, .o_pump_cal_stage_enable, .o_oscillator_core_select,
    .o_oscillator_select_cal_enable, .o_offset_comp_enable, .o_vco_current, .o_coarse_tune);
`default_nettype wire

// File: verif/synth_regs_monitor.sv
// assertion checker for the synthesizer calibration, test and status registers
`timescale 1ns/1ns
`default_nettype none
module synth_regs_monitor
    import synth_regs_pkg::*;
(
    input wire logic       i_clock,
    input wire logic       i_rst,
    input wire logic       i_reg_write,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_modulation,
    input wire logic       i_crc_done,
    input wire logic       i_crc_match,
    input wire logic       i_rx_start,
    input wire logic       o_pump_cal_stage_enable,
    input wire logic       o_oscillator_core_select,
    input wire logic       o_oscillator_select_cal_enable,
    input wire logic       o_offset_comp_enable,
    input wire logic [4:0] o_vco_current,
    input wire logic [5:0] o_coarse_tune
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    a_pump_stage_gate: assert property (i_reg_addr == ADDR_SYNTH_CAL_PUMP |->
        o_pump_cal_stage_enable == (o_reg_rdata[5:4] != 2'b00)) else $error("pump stage gate");
    a_core_select_bit: assert property (i_reg_addr == ADDR_SYNTH_CAL_VCO_CURRENT |->
        o_oscillator_core_select == o_reg_rdata[5]) else $error("core select bit");
    a_vco_current_field: assert property (i_reg_addr == ADDR_SYNTH_CAL_VCO_CURRENT |->
        o_vco_current == o_reg_rdata[4:0]) else $error("vco current field");
    a_coarse_tune_field: assert property (i_reg_addr == ADDR_SYNTH_CAL_COARSE_TUNE |->
        {2'b00, o_coarse_tune} == o_reg_rdata) else $error("coarse tune field");
    a_osc_sel_cal: assert property (i_reg_addr == ADDR_TEST_SETTING_ZERO |->
        o_oscillator_select_cal_enable == o_reg_rdata[1]) else $error("osc select cal");
    a_offset_ook_zero: assert property (i_modulation == MOD_OOK
        && i_reg_addr == ADDR_CARRIER_OFFSET_EST |-> o_reg_rdata == 8'h00) else $error("ook offset");
    a_comp_mode_gate: assert property ($changed(i_modulation) |=>
        o_offset_comp_enable == (i_modulation != MOD_OOK)) else $error("comp mode gate");
    a_crc_flag_set: assert property (i_crc_done ##1 i_reg_addr == ADDR_CRC_MATCH_STATUS |->
        o_reg_rdata[7] == $past(i_crc_match)) else $error("crc flag set");
    a_crc_flag_clear: assert property ((i_rx_start && !i_crc_done) ##1
        i_reg_addr == ADDR_CRC_MATCH_STATUS |-> !o_reg_rdata[7]) else $error("crc flag clear");
    a_pump_write_read: assert property ((i_reg_write && i_reg_addr == ADDR_SYNTH_CAL_PUMP) ##1
        i_reg_addr == ADDR_SYNTH_CAL_PUMP |-> o_reg_rdata == $past(i_reg_wdata)) else $error("pump rw");
    a_id_write_ignored: assert property ((i_reg_write && i_reg_addr == ADDR_CHIP_PART_ID) ##1
        i_reg_addr == ADDR_CHIP_PART_ID |-> $stable(o_reg_rdata)) else $error("id write");
    c_crc_match: cover property (i_crc_done && i_crc_match);
    c_id_write: cover property (i_reg_write && i_reg_addr == ADDR_CHIP_PART_ID);
    c_ook_read: cover property (i_modulation == MOD_OOK && i_reg_addr == ADDR_CARRIER_OFFSET_EST);
endmodule
`default_nettype wire
